/* File: inc/bwu_pkg.sv */
// package: register map, field layout and message codes of the breakpoint unit
package bwu_pkg;
  localparam int NUM_PROG = 6;
  localparam int NUM_DATA = 2;
  // register byte offsets
  localparam logic [7:0] OFF_PADDR0 = 8'h00;
  localparam logic [7:0] OFF_PCTRL0 = 8'h20;
  localparam logic [7:0] OFF_PAIRCTL = 8'h40;
  localparam logic [7:0] OFF_DADDR0 = 8'h44;
  localparam logic [7:0] OFF_DVAL0 = 8'h4C;
  localparam logic [7:0] OFF_DCTRL0 = 8'h54;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h5C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h60;
  // control register fields
  localparam int F_EN_HI = 31;
  localparam int F_EN_LO = 30;
  localparam int F_MASK_EN = 25;
  localparam int F_EVT_OUT = 14;
  localparam int F_SID_HI = 8;
  localparam int F_SID_LO = 1;
  localparam int F_SID_EN = 0;
  localparam logic [31:0] PCTRL_WMASK = 32'hC200_41FF;
  localparam logic [31:0] DCTRL_WMASK = 32'hC000_01FF;
  localparam logic [31:0] PAIR_WMASK = 32'h0000_0007;
  localparam int F_WIDE = 2;
  localparam logic [1:0] EN_OFF = 2'b00;
  localparam logic [1:0] EN_BREAK = 2'b01;
  localparam logic [1:0] EN_WATCH = 2'b11;
  localparam logic [1:0] RNG_OFF = 2'b00;
  localparam logic [1:0] RNG_EXCL = 2'b01;
  localparam logic [1:0] RNG_INCL = 2'b10;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // message codes
  localparam logic [5:0] HIT_CODE = 6'd15;
  localparam logic [5:0] TRACE_HIT_CODE = 6'd56;
  // interrupt status bits
  localparam int IRQ_BREAK = 0;
  localparam int IRQ_WATCH = 1;
  localparam int IRQ_TRACE = 2;
  localparam int IRQ_BITS = 3;

  typedef struct packed {
    logic valid;
    logic [7:0] hit_bit_field;
    logic [5:0] code;
  } bwu_msg_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] value;
  } bwu_data_access_type;
endpackage

/* File: src/bwu_cmp.sv */
// one address comparator with space identifier qualification
`timescale 1ns/1ps
module bwu_cmp
(
  input wire logic [31:0] pc_i,
  input wire logic [31:0] ref_i,
  input wire logic [31:0] mask_i,
  input wire logic [7:0] sid_i,
  input wire logic [31:0] ctrl_i,
  output logic match_o
);
  logic sid_ok;
  always_comb
  begin
    // identifier is ignored unless its enable bit is set
    sid_ok = !ctrl_i[bwu_pkg::F_SID_EN] ||
      (sid_i == ctrl_i[bwu_pkg::F_SID_HI:bwu_pkg::F_SID_LO]);
    match_o = sid_ok && ((pc_i & mask_i) == (ref_i & mask_i));
  end
endmodule

/* File: src/bwu_top.sv */
// breakpoint and watchpoint comparator unit with apb registers
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module bwu_top
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [31:0] pc_i,
  input wire logic pc_valid_i,
  input wire logic [7:0] space_id_i,
  input wire bwu_pkg::bwu_data_access_type data_i,
  input wire logic [1:0] trace_wp_i,
  output bwu_pkg::bwu_msg_type msg_o,
  output logic break_o,
  output logic event_output_pin_o,
  output logic irq_o
);
  localparam int NP = bwu_pkg::NUM_PROG;
  localparam int ND = bwu_pkg::NUM_DATA;

  typedef struct packed {
    logic [NP-1:0][31:0] paddr;
    logic [NP-1:0][31:0] pctrl;
    logic [31:0] pair;
    logic [ND-1:0][31:0] daddr;
    logic [ND-1:0][31:0] dval;
    logic [ND-1:0][31:0] dctrl;
    logic [bwu_pkg::IRQ_BITS-1:0] stat;
    logic [bwu_pkg::IRQ_BITS-1:0] mask;
    logic [31:0] rdata;
    bwu_pkg::bwu_msg_type msg;
    logic brk;
    logic evt;
  } bwu_state_type;

  bwu_state_type state;
  bwu_state_type next_state;
  logic [NP-1:0] pmatch;
  logic [NP-1:0] pfire;
  logic [ND-1:0] dmatch;
  logic [ND-1:0] dfire;
  logic [7:0] wp_hits;
  logic [7:0] bp_hits;
  logic [7:0] evt_hits;
  logic acc;
  logic wr;
  logic hit_addr;
  logic [31:0] rd;
  logic [bwu_pkg::IRQ_BITS-1:0] ev;

  // index of a register within a group of consecutive words, or -1 on miss
  function automatic int reg_index(input logic [31:0] a, input logic [7:0] base, input int n);
    int r;
    r = -1;
    for (int k = 0; k < n; k++)
    begin
      if (a == {24'h00_0000, base} + 32'(4 * k))
      begin
        r = k;
      end
    end
    return r;
  endfunction

  // enable decode shared by every comparator
  function automatic logic is_watch(input logic [31:0] c);
    return c[bwu_pkg::F_EN_HI:bwu_pkg::F_EN_LO] == bwu_pkg::EN_WATCH;
  endfunction

  function automatic logic is_break(input logic [31:0] c);
    return c[bwu_pkg::F_EN_HI:bwu_pkg::F_EN_LO] == bwu_pkg::EN_BREAK;
  endfunction

  // program comparators, grouped in A/B pairs
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_prog
      localparam int PARTNER = g ^ 1;
      logic is_a;
      logic masked;
      assign is_a = (g % 2) == 0;
      assign masked = state.pctrl[g & ~1][bwu_pkg::F_MASK_EN];
      bwu_cmp u_cmp
      (
        .pc_i(pc_i),
        .ref_i(state.paddr[g]),
        .mask_i((is_a && masked) ? state.paddr[PARTNER] : 32'hFFFF_FFFF),
        .sid_i(space_id_i),
        .ctrl_i(state.pctrl[g]),
        .match_o(pmatch[g])
      );
      // b of a masked pair never fires
      assign pfire[g] = pc_valid_i && pmatch[g] && !(!is_a && masked);
    end
  endgenerate

  // data comparators: address and value, qualified like the program ones
  generate
    for (g = 0; g < ND; g++)
    begin : g_data
      logic amatch;
      bwu_cmp u_cmp
      (
        .pc_i(data_i.addr),
        .ref_i(state.daddr[g]),
        .mask_i(32'hFFFF_FFFF),
        .sid_i(space_id_i),
        .ctrl_i(state.dctrl[g]),
        .match_o(amatch)
      );
      // value compare is skipped while a range is active
      assign dmatch[g] = amatch && (state.pair[1:0] != bwu_pkg::RNG_OFF ||
        data_i.value == state.dval[g]);
    end
  endgenerate

  always_comb
  begin
    logic [1:0] range_select;
    logic id_ok;
    logic in_lo;
    logic in_hi;
    range_select = state.pair[1:0];
    id_ok = !state.dctrl[0][bwu_pkg::F_SID_EN] ||
      space_id_i == state.dctrl[0][bwu_pkg::F_SID_HI:bwu_pkg::F_SID_LO];
    in_lo = data_i.addr <= state.daddr[0];
    in_hi = data_i.addr <= state.daddr[1];
    dfire = '0;
    if (data_i.valid)
    begin
      unique case (range_select)
        bwu_pkg::RNG_EXCL: dfire[0] = id_ok && (in_lo || !in_hi);
        bwu_pkg::RNG_INCL: dfire[0] = id_ok && !in_lo && in_hi;
        bwu_pkg::RNG_OFF:
        begin
          if (state.pair[bwu_pkg::F_WIDE])
          begin
            // a and b must both match the same address and value; b's own enable is ignored
            dfire[0] = dmatch[0] && dmatch[1];
          end
          else
          begin
            dfire = dmatch;
          end
        end
        default: dfire = '0; // reserved range code matches nothing
      endcase
    end
  end

  always_comb
  begin
    wp_hits = '0;
    bp_hits = '0;
    evt_hits = '0;
    for (int k = 0; k < NP; k++)
    begin
      wp_hits[k] = pfire[k] && is_watch(state.pctrl[k]);
      bp_hits[k] = pfire[k] && is_break(state.pctrl[k]);
      evt_hits[k] = (wp_hits[k] || bp_hits[k]) && state.pctrl[k][bwu_pkg::F_EVT_OUT];
    end
    for (int k = 0; k < ND; k++)
    begin
      wp_hits[NP+k] = dfire[k] && is_watch(state.dctrl[k]);
      bp_hits[NP+k] = dfire[k] && is_break(state.dctrl[k]);
    end
  end

  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign ev = {trace_wp_i != 2'b00, |wp_hits, |bp_hits};

  // read mux; reserved bits are already zero in storage
  always_comb
  begin
    int ip;
    int id;
    int iv;
    int ic;
    ip = reg_index(paddr_i, bwu_pkg::OFF_PADDR0, NP);
    ic = reg_index(paddr_i, bwu_pkg::OFF_PCTRL0, NP);
    id = reg_index(paddr_i, bwu_pkg::OFF_DADDR0, ND);
    iv = reg_index(paddr_i, bwu_pkg::OFF_DVAL0, ND);
    rd = bwu_pkg::RESET_WORD;
    hit_addr = 1'b1;
    if (ip >= 0)
    begin
      rd = state.paddr[ip];
    end
    else if (ic >= 0)
    begin
      rd = state.pctrl[ic];
    end
    else if (id >= 0)
    begin
      rd = state.daddr[id];
    end
    else if (iv >= 0)
    begin
      rd = state.dval[iv];
    end
    else if (reg_index(paddr_i, bwu_pkg::OFF_DCTRL0, ND) >= 0)
    begin
      rd = state.dctrl[reg_index(paddr_i, bwu_pkg::OFF_DCTRL0, ND)];
    end
    else if (paddr_i == {24'h00_0000, bwu_pkg::OFF_PAIRCTL})
    begin
      rd = state.pair;
    end
    else if (paddr_i == {24'h00_0000, bwu_pkg::OFF_IRQ_STAT})
    begin
      rd = {29'h0000_0000, state.stat};
    end
    else if (paddr_i == {24'h00_0000, bwu_pkg::OFF_IRQ_MASK})
    begin
      rd = {29'h0000_0000, state.mask};
    end
    else
    begin
      hit_addr = 1'b0;
    end
  end

  always_comb
  begin
    int k;
    k = 0;
    next_state = state;
    if (wr)
    begin
      k = reg_index(paddr_i, bwu_pkg::OFF_PADDR0, NP);
      if (k >= 0)
      begin
        next_state.paddr[k] = pwdata_i;
      end
      k = reg_index(paddr_i, bwu_pkg::OFF_PCTRL0, NP);
      if (k >= 0)
      begin
        // mask enable exists only in the a register of a pair
        next_state.pctrl[k] = pwdata_i & bwu_pkg::PCTRL_WMASK &
          ((k % 2) == 0 ? 32'hFFFF_FFFF : 32'hFDFF_FFFF);
      end
      k = reg_index(paddr_i, bwu_pkg::OFF_DADDR0, ND);
      if (k >= 0)
      begin
        next_state.daddr[k] = pwdata_i;
      end
      k = reg_index(paddr_i, bwu_pkg::OFF_DVAL0, ND);
      if (k >= 0)
      begin
        next_state.dval[k] = pwdata_i;
      end
      k = reg_index(paddr_i, bwu_pkg::OFF_DCTRL0, ND);
      if (k >= 0)
      begin
        next_state.dctrl[k] = pwdata_i & bwu_pkg::DCTRL_WMASK;
      end
      if (paddr_i == {24'h00_0000, bwu_pkg::OFF_PAIRCTL})
      begin
        next_state.pair = pwdata_i & bwu_pkg::PAIR_WMASK;
      end
      if (paddr_i == {24'h00_0000, bwu_pkg::OFF_IRQ_MASK})
      begin
        next_state.mask = pwdata_i[bwu_pkg::IRQ_BITS-1:0];
      end
    end
    // write-one-to-clear, but a new event in the same cycle wins
    if (wr && paddr_i == {24'h00_0000, bwu_pkg::OFF_IRQ_STAT})
    begin
      next_state.stat = state.stat & ~pwdata_i[bwu_pkg::IRQ_BITS-1:0];
    end
    next_state.stat = next_state.stat | ev;
    next_state.rdata = (acc && !pwrite_i) ? rd : state.rdata;
    // one message per cycle; watchpoint hits take precedence over trace hits
    next_state.msg.valid = 1'b0;
    next_state.msg.hit_bit_field = '0;
    next_state.msg.code = '0;
    if (|wp_hits)
    begin
      next_state.msg.valid = 1'b1;
      next_state.msg.hit_bit_field = wp_hits;
      next_state.msg.code = bwu_pkg::HIT_CODE;
    end
    else if (trace_wp_i != 2'b00)
    begin
      next_state.msg.valid = 1'b1;
      next_state.msg.hit_bit_field = {6'b00_0000, trace_wp_i};
      next_state.msg.code = bwu_pkg::TRACE_HIT_CODE;
    end
    next_state.brk = |bp_hits;
    next_state.evt = |evt_hits;
    if (sys_rst_i)
    begin
      next_state = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    state <= next_state;
  end

  // zero-wait slave: answer in the access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !hit_addr;
  assign prdata_o = rd;
  assign msg_o = state.msg;
  assign break_o = state.brk;
  assign event_output_pin_o = state.evt;
  assign irq_o = |(state.stat & state.mask);
endmodule

/* File: tb/bwu_dbg_model.sv */
// debugger model that collects hit messages from the debug port
`timescale 1ns/1ps
module bwu_dbg_model
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire bwu_pkg::bwu_msg_type msg_i,
  output logic [14:0] last_o,
  output logic [15:0] count_o
);
  // the debugger only listens, so a message is taken whole on its one valid cycle
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      last_o <= 15'h0000;
      count_o <= 16'h0000;
    end
    else if (msg_i.valid)
    begin
      last_o <= msg_i;
      count_o <= count_o + 16'h0001;
    end
  end
endmodule

/* File: tb/bwu_chk_sva.sv */
// concurrent checks on the ports of the breakpoint unit
`timescale 1ns/1ps
module bwu_chk
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic pc_valid_i,
  input wire bwu_pkg::bwu_data_access_type data_i,
  input wire logic [1:0] trace_wp_i,
  input wire bwu_pkg::bwu_msg_type msg_o,
  input wire logic break_o,
  input wire logic event_output_pin_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_access;
    psel_i && penable_i;
  endsequence
  sequence s_trace_msg;
    msg_o.valid && msg_o.code == bwu_pkg::TRACE_HIT_CODE;
  endsequence
  chk_msg_code: assert property (msg_o.valid |->
    msg_o.code == bwu_pkg::HIT_CODE || msg_o.code == bwu_pkg::TRACE_HIT_CODE)
    else $error("message code outside the two known codes");
  chk_hit_field: assert property (msg_o.valid && msg_o.code == bwu_pkg::HIT_CODE |->
    msg_o.hit_bit_field != 8'h00) else $error("hit message without hit bit");
  chk_trace_field: assert property (s_trace_msg |->
    msg_o.hit_bit_field == {6'h00, $past(trace_wp_i)}) else $error("trace hit field wrong");
  chk_break_cause: assert property (break_o |-> $past(pc_valid_i) || $past(data_i.valid))
    else $error("breakpoint without access");
  chk_event_cause: assert property (event_output_pin_o |-> $past(pc_valid_i))
    else $error("event pin without program access");
  chk_unmapped_err: assert property (s_access and (paddr_i >= 32'h0000_0064) |->
    pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped access not refused");
  chk_mapped_ok: assert property (s_access and (paddr_i <= 32'h0000_0014) |-> !pslverr_o)
    else $error("mapped access refused");
  chk_ready_high: assert property (s_access |-> pready_o) else $error("no ready");
  chk_reset_quiet: assert property (disable iff (1'b0) sys_rst_i ##1 sys_rst_i |->
    !msg_o.valid && !break_o && !irq_o) else $error("outputs active in reset");
endmodule
bind bwu_top bwu_chk bwu_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .pc_valid_i(pc_valid_i), .data_i(data_i), .trace_wp_i(trace_wp_i),
  .msg_o(msg_o), .break_o(break_o), .event_output_pin_o(event_output_pin_o), .irq_o(irq_o));

/* File: tb/testbench.sv */
// self-checking bench for the breakpoint unit
`timescale 1ns/1ps
module testbench;
  logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pc_valid_i, pready_o, pslverr_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, pc_i;
  logic [7:0] space_id_i;
  logic [1:0] trace_wp_i;
  logic break_o, event_output_pin_o, irq_o;
  logic [14:0] last_msg;
  logic [15:0] msg_count;
  bwu_pkg::bwu_data_access_type data_i;
  bwu_pkg::bwu_msg_type msg_o;
  int n_mismatch, num_checks, exp_msgs;
  bwu_top bwu_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pc_i(pc_i),
    .pc_valid_i(pc_valid_i), .space_id_i(space_id_i), .data_i(data_i),
    .trace_wp_i(trace_wp_i), .msg_o(msg_o), .break_o(break_o),
    .event_output_pin_o(event_output_pin_o), .irq_o(irq_o));
  bwu_dbg_model bwu_dbg_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .msg_i(msg_o),
    .last_o(last_msg), .count_o(msg_count));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // apb master: setup, then access held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {24'h00_0000, a};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1)
      n_mismatch++;
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    cmp(r, x);
    cmp({31'h0, e}, {31'h0, xe});
  endtask
  // one cycle of core activity, outputs judged on the following cycle
  task automatic go(input logic [31:0] pc, input logic [7:0] sid, input logic dv,
    input logic [31:0] da, input logic [1:0] tw, input logic [14:0] xm);
    @(posedge clk_i);
    pc_i <= pc;
    pc_valid_i <= ~dv;
    space_id_i <= sid;
    data_i <= {dv, 1'b1, da, 32'h0000_0000};
    trace_wp_i <= tw;
    @(posedge clk_i);
    pc_valid_i <= 1'b0;
    data_i <= '0;
    trace_wp_i <= 2'b00;
    #1;
    cmp({17'h0_0000, msg_o}, {17'h0_0000, xm});
    if (xm[14])
      exp_msgs++;
  endtask
  function automatic logic [14:0] m(input logic [7:0] f, input logic [5:0] c);
    return {1'b1, f, c};
  endfunction
  task automatic t_regs;
    rd(bwu_pkg::OFF_PADDR0, 32'h0000_0000, 1'b0);
    rd(bwu_pkg::OFF_PCTRL0, 32'h0000_0000, 1'b0);
    rd(bwu_pkg::OFF_PAIRCTL, 32'h0000_0000, 1'b0);
    rd(bwu_pkg::OFF_DADDR0, 32'h0000_0000, 1'b0);
    rd(bwu_pkg::OFF_DVAL0, 32'h0000_0000, 1'b0);
    rd(8'h64, 32'h0000_0000, 1'b1);
    wr(bwu_pkg::OFF_PADDR0, 32'hA5A5_5A5A);
    rd(bwu_pkg::OFF_PADDR0, 32'hA5A5_5A5A, 1'b0);
    wr(bwu_pkg::OFF_PCTRL0, 32'hFFFF_FFFF);
    rd(bwu_pkg::OFF_PCTRL0, bwu_pkg::PCTRL_WMASK, 1'b0);
    wr(bwu_pkg::OFF_PAIRCTL, 32'hFFFF_FFFF);
    rd(bwu_pkg::OFF_PAIRCTL, bwu_pkg::PAIR_WMASK, 1'b0);
    wr(bwu_pkg::OFF_PAIRCTL, 32'h0000_0000);
  endtask
  task automatic t_prog;
    wr(bwu_pkg::OFF_IRQ_MASK, 32'h0000_0007);
    wr(bwu_pkg::OFF_PADDR0, 32'h0000_1000);
    wr(bwu_pkg::OFF_PCTRL0, {bwu_pkg::EN_WATCH, 30'h0000_4000});
    go(32'h0000_1000, 8'h00, 1'b0, 32'h0, 2'b00, m(8'h01, bwu_pkg::HIT_CODE));
    cmp({31'h0, event_output_pin_o}, 32'h0000_0001);
    cmp({31'h0, irq_o}, 32'h0000_0001);
    rd(bwu_pkg::OFF_IRQ_STAT, 32'h0000_0002, 1'b0);
    wr(bwu_pkg::OFF_IRQ_STAT, 32'h0000_0002);
    // let the clearing edge settle before looking at the level output
    #1;
    cmp({31'h0, irq_o}, 32'h0000_0000);
    wr(8'h04, 32'h0000_2000);
    wr(8'h24, {bwu_pkg::EN_BREAK, 30'h0});
    go(32'h0000_2000, 8'h00, 1'b0, 32'h0, 2'b00, 15'h0000);
    cmp({31'h0, break_o}, 32'h0000_0001);
    cmp({31'h0, event_output_pin_o}, 32'h0000_0000);
    wr(8'h24, 32'h0000_0000);
    go(32'h0000_2000, 8'h00, 1'b0, 32'h0, 2'b00, 15'h0000);
    cmp({31'h0, break_o}, 32'h0000_0000);
    // trace alone, then trace in the same cycle as a watchpoint
    go(32'h0000_0000, 8'h00, 1'b0, 32'h0, 2'b10, m(8'h02, bwu_pkg::TRACE_HIT_CODE));
    go(32'h0000_1000, 8'h00, 1'b0, 32'h0, 2'b01, m(8'h01, bwu_pkg::HIT_CODE));
  endtask
  task automatic t_asid_mask;
    wr(bwu_pkg::OFF_PCTRL0, {bwu_pkg::EN_WATCH, 21'h0, 8'h5A, 1'b1});
    go(32'h0000_1000, 8'h11, 1'b0, 32'h0, 2'b00, 15'h0000);
    go(32'h0000_1000, 8'h5A, 1'b0, 32'h0, 2'b00, m(8'h01, bwu_pkg::HIT_CODE));
    wr(bwu_pkg::OFF_PADDR0, 32'h0000_2000);
    wr(8'h04, 32'hFFFF_F000);
    wr(bwu_pkg::OFF_PCTRL0, {bwu_pkg::EN_WATCH, 4'h0, 1'b1, 25'h0});
    wr(8'h24, {bwu_pkg::EN_WATCH, 30'h0});
    go(32'h0000_2ABC, 8'h00, 1'b0, 32'h0, 2'b00, m(8'h01, bwu_pkg::HIT_CODE));
    go(32'hFFFF_F000, 8'h00, 1'b0, 32'h0, 2'b00, 15'h0000);
    wr(bwu_pkg::OFF_PCTRL0, 32'h0000_0000);
    wr(8'h24, 32'h0000_0000);
  endtask
  task automatic t_range;
    wr(bwu_pkg::OFF_DADDR0, 32'h0000_0100);
    wr(8'h48, 32'h0000_0200);
    wr(bwu_pkg::OFF_DCTRL0, {bwu_pkg::EN_WATCH, 30'h0});
    wr(8'h58, {bwu_pkg::EN_WATCH, 30'h0});
    wr(bwu_pkg::OFF_PAIRCTL, {30'h0, bwu_pkg::RNG_INCL});
    go(32'h0, 8'h00, 1'b1, 32'h0000_0100, 2'b00, 15'h0000);
    go(32'h0, 8'h00, 1'b1, 32'h0000_0180, 2'b00, m(8'h40, bwu_pkg::HIT_CODE));
    go(32'h0, 8'h00, 1'b1, 32'h0000_0200, 2'b00, m(8'h40, bwu_pkg::HIT_CODE));
    wr(bwu_pkg::OFF_PAIRCTL, {30'h0, bwu_pkg::RNG_EXCL});
    go(32'h0, 8'h00, 1'b1, 32'h0000_0100, 2'b00, m(8'h40, bwu_pkg::HIT_CODE));
    go(32'h0, 8'h00, 1'b1, 32'h0000_0180, 2'b00, 15'h0000);
    go(32'h0, 8'h00, 1'b1, 32'h0000_0201, 2'b00, m(8'h40, bwu_pkg::HIT_CODE));
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    exp_msgs = 0;
    {sys_rst_i, psel_i, penable_i, pwrite_i, pc_valid_i} = 5'b10000;
    {paddr_i, pwdata_i, pc_i, space_id_i, trace_wp_i} = '0;
    data_i = '0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_prog();
    t_asid_mask();
    t_range();
    // the debugger takes the last message one edge after the bench judged it
    @(posedge clk_i);
    #1;
    cmp({16'h0000, msg_count}, exp_msgs);
    cmp({17'h0_0000, last_msg}, {17'h0_0000, m(8'h40, bwu_pkg::HIT_CODE)});
    print_verdict();
  end
endmodule
